// *** core/hps_pkg.sv ***
// Shared constants for the host port status and synchronisation block
package hps_pkg;
    // Core-side register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RXWORD = 8'h08;
    localparam logic [7:0] ADDR_TXWORD = 8'h0C;
    localparam logic [7:0] ADDR_VECTOR = 8'h10;
    localparam logic [7:0] ADDR_CMDACK = 8'h14;
    localparam logic [7:0] ADDR_IRQSTAT = 8'h18;
    localparam logic [7:0] ADDR_IRQMASK = 8'h1C;
    localparam int unsigned ADDR_LSB = 2;
    localparam int unsigned ADDR_MSB = 7;
    // Core control register fields
    localparam int unsigned CTRL_FLAG_A = 0;
    localparam int unsigned CTRL_FLAG_B = 1;
    // Core status register fields
    localparam int unsigned ST_RX_FULL = 0;
    localparam int unsigned ST_TX_EMPTY = 1;
    localparam int unsigned ST_CMD = 2;
    localparam int unsigned ST_FLAG_A = 3;
    localparam int unsigned ST_FLAG_B = 4;
    localparam int unsigned ST_MODE = 5;
    // Interrupt event bits
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned EV_RX = 0;
    localparam int unsigned EV_TX = 1;
    localparam int unsigned EV_CMD = 2;
    // Host-side register addresses
    localparam logic [1:0] HA_CTRL = 2'h0;
    localparam logic [1:0] HA_CMD = 2'h1;
    localparam logic [1:0] HA_HIGH = 2'h2;
    localparam logic [1:0] HA_LOW = 2'h3;
    // Host control byte fields
    localparam int unsigned HC_FLAG_A = 0;
    localparam int unsigned HC_FLAG_B = 1;
    localparam int unsigned HC_MODE = 2;
    localparam int unsigned HC_REQ_EN = 3;
    // Host command byte fields
    localparam int unsigned HCMD_PEND = 7;
    localparam int unsigned VEC_W = 5;
    // Host status byte fields
    localparam int unsigned HS_RX_FULL = 0;
    localparam int unsigned HS_TX_EMPTY = 1;
    localparam int unsigned HS_TRANSMITTER_READY_FLAG = 2;
    localparam int unsigned HS_FLAG_A = 3;
    localparam int unsigned HS_FLAG_B = 4;
    localparam int unsigned HS_REQ = 5;
    localparam int unsigned HS_MODE = 6;
    localparam int unsigned HS_CMD = 7;
    // Widths and AHB codes
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned CORE_SYNC_W = 6;
    localparam int unsigned PIN_SYNC_W = 12;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : hps_pkg

// *** core/hps_sync.sv ***
// Two-flop synchroniser, one independent chain per bit
module hps_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    ////////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic meta_q;
            logic meta_d;
            logic stab_q;
            logic stab_d;
            // Next values of both stages
            always_comb
            begin
                meta_d = async_in[gi];
                stab_d = meta_q;
            end
            // First stage read only by the second
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    meta_q <= RST_VAL[gi]; // Idle level of the pin
                    stab_q <= RST_VAL[gi];
                end
                else
                begin
                    meta_q <= meta_d;
                    stab_q <= stab_d;
                end
            end
            assign sync_out[gi] = stab_q;
        end
    endgenerate
endmodule : hps_sync

// *** core/hps_irq.sv ***
// Sticky interrupt status with mask and one level output
module hps_irq #(
    parameter int unsigned W = hps_pkg::IRQ_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] event_set,
    input wire logic clear_wr,
    input wire logic mask_wr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] status_q,
    output logic [W-1:0] mask_q,
    output logic irq_q
);
    ////////////////////////////////////////////////////////////////////////
    logic [W-1:0] status_d;
    logic [W-1:0] mask_d;
    logic irq_d;

    // Write one to clear; a same-cycle event wins
    always_comb
    begin
        status_d = status_q;
        if (clear_wr)
            status_d = status_d & ~wdata;
        status_d = status_d | event_set;
        mask_d = mask_wr ? wdata : mask_q;
        irq_d = |(status_q & mask_q);
    end

    // Register state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            status_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
        (|(status_q & mask_q)) |=> irq_q;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt not raised for unmasked status");
endmodule : hps_irq

// *** core/hps_host_port.sv ***
// Host port: asynchronous byte-wide host side and AHB-Lite core side
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
module hps_host_port (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic host_interface_enable_n,
    input wire logic host_read_write,
    input wire logic [1:0] host_addr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic host_request_n
);
    ////////////////////////////////////////////////////////////////////////
    // Host pin synchronisation
    logic [hps_pkg::PIN_SYNC_W-1:0] pin_s;
    logic en_n_s;
    logic rw_s;
    logic [1:0] ha_s;
    logic [7:0] din_s;
    // Enable chain resets high so no false access follows reset
    localparam logic [hps_pkg::PIN_SYNC_W-1:0] PIN_RST = {1'b1, {(hps_pkg::PIN_SYNC_W-1){1'b0}}};

    hps_sync #(.WIDTH(hps_pkg::PIN_SYNC_W), .RST_VAL(PIN_RST)) u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({host_interface_enable_n, host_read_write, host_addr, host_data_in}),
        .sync_out(pin_s)
    );
    assign {en_n_s, rw_s, ha_s, din_s} = pin_s;

    ////////////////////////////////////////////////////////////////////////
    // State
    logic en_prev_q, en_prev_d;
    logic acc_rd_q, acc_rd_d;
    logic [1:0] acc_addr_q, acc_addr_d;
    logic [7:0] rx_high_q, rx_high_d, rx_low_q, rx_low_d;
    logic rx_full_q, rx_full_d;
    logic [7:0] tx_high_q, tx_high_d;
    logic xfer_full_q, xfer_full_d;
    logic [hps_pkg::WORD_W-1:0] core_word_q, core_word_d;
    logic flag_a_q, flag_a_d, flag_b_q, flag_b_d, mode_q, mode_d, req_en_q, req_en_d;
    logic cmd_pend_q, cmd_pend_d;
    logic [hps_pkg::VEC_W-1:0] vector_q, vector_d, vec_core_q, vec_core_d;
    logic [1:0] to_host_q, to_host_d;
    logic [7:0] hdout_q, hdout_d;
    logic hoe_q, hoe_d;
    logic host_request_flag_n_q, host_request_flag_n_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic dp_wr_q, dp_wr_d;
    logic [7:0] dp_addr_q, dp_addr_d;
    logic cmd_prev_q, cmd_prev_d, rxf_prev_q, rxf_prev_d, txe_prev_q, txe_prev_d;

    logic acc_start, acc_end, host_wr, ahb_take, core_rd_word;
    logic wr_ctrl, wr_tx, wr_ack, wr_istat, wr_imask;
    logic [hps_pkg::CORE_SYNC_W-1:0] core_s;
    logic core_rxf_s, core_txe_s, cmd_core_s, fh_a_s, fh_b_s, mode_s;
    logic [hps_pkg::IRQ_W-1:0] ev, irq_stat, irq_mask;
    logic [7:0] stat_now;

    ////////////////////////////////////////////////////////////////////////
    // Host status byte, used for reads and for the request pin
    function automatic logic [7:0] host_status(
        input logic rxf, input logic xfull, input logic crxf, input logic [1:0] th,
        input logic ren, input logic md, input logic cp);
        logic [7:0] s;
        s = '0;
        s[hps_pkg::HS_RX_FULL] = rxf;
        s[hps_pkg::HS_TX_EMPTY] = !xfull;
        s[hps_pkg::HS_TRANSMITTER_READY_FLAG] = !xfull && !crxf;
        s[hps_pkg::HS_FLAG_A] = th[0];
        s[hps_pkg::HS_FLAG_B] = th[1];
        s[hps_pkg::HS_REQ] = ren && (rxf || !xfull);
        s[hps_pkg::HS_MODE] = md;
        s[hps_pkg::HS_CMD] = cp;
        return s;
    endfunction : host_status

    // Core-visible copies of host-driven bits, each on its own chain
    hps_sync #(.WIDTH(hps_pkg::CORE_SYNC_W)) u_core_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({mode_q, flag_b_q, flag_a_q, cmd_pend_q, !rx_full_q, xfer_full_q}),
        .sync_out(core_s)
    );
    assign {mode_s, fh_b_s, fh_a_s, cmd_core_s, core_txe_s, core_rxf_s} = core_s;
    // Current host status byte
    assign stat_now = host_status(rx_full_q, xfer_full_q, core_rxf_s, to_host_q, req_en_q,
        mode_q, cmd_pend_q);

    // Bus and host access decode
    assign acc_start = en_prev_q && !en_n_s;
    assign acc_end = !en_prev_q && en_n_s;
    assign host_wr = acc_start && !rw_s;
    assign ahb_take = hsel && hready && htrans[1];
    assign core_rd_word = ahb_take && !hwrite && haddr[7:0] == hps_pkg::ADDR_RXWORD;
    assign wr_ctrl = dp_wr_q && dp_addr_q == hps_pkg::ADDR_CTRL;
    assign wr_tx = dp_wr_q && dp_addr_q == hps_pkg::ADDR_TXWORD;
    assign wr_ack = dp_wr_q && dp_addr_q == hps_pkg::ADDR_CMDACK && hwdata[0];
    assign wr_istat = dp_wr_q && dp_addr_q == hps_pkg::ADDR_IRQSTAT;
    assign wr_imask = dp_wr_q && dp_addr_q == hps_pkg::ADDR_IRQMASK;
    assign ev[hps_pkg::EV_RX] = core_rxf_s && !rxf_prev_q;
    assign ev[hps_pkg::EV_TX] = core_txe_s && !txe_prev_q;
    assign ev[hps_pkg::EV_CMD] = cmd_core_s && !cmd_prev_q;

    hps_irq #(.W(hps_pkg::IRQ_W)) u_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .event_set(ev),
        .clear_wr(wr_istat),
        .mask_wr(wr_imask),
        .wdata(hwdata[hps_pkg::IRQ_W-1:0]),
        .status_q(irq_stat),
        .mask_q(irq_mask),
        .irq_q(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state for host side and core side
    always_comb
    begin
        en_prev_d = en_n_s;
        acc_rd_d = acc_start ? rw_s : acc_rd_q;
        acc_addr_d = acc_start ? ha_s : acc_addr_q;
        rx_high_d = rx_high_q;
        rx_low_d = rx_low_q;
        rx_full_d = rx_full_q;
        tx_high_d = tx_high_q;
        xfer_full_d = xfer_full_q;
        core_word_d = core_word_q;
        flag_a_d = flag_a_q;
        flag_b_d = flag_b_q;
        mode_d = mode_q;
        req_en_d = req_en_q;
        cmd_pend_d = cmd_pend_q;
        vector_d = vector_q;
        vec_core_d = vec_core_q;
        to_host_d = to_host_q;
        hdout_d = hdout_q;
        hoe_d = hoe_q;
        cmd_prev_d = cmd_core_s;
        rxf_prev_d = core_rxf_s;
        txe_prev_d = core_txe_s;
        // Core acknowledge withdraws the command before any host write
        if (wr_ack)
            cmd_pend_d = 1'b0;
        // Read side effect only at the end of the host access
        if (acc_end && acc_rd_q && acc_addr_q == hps_pkg::HA_LOW)
            rx_full_d = 1'b0;
        if (core_rd_word)
            xfer_full_d = 1'b0;
        // Host writes, taken at access start
        if (host_wr)
        begin
            unique case (ha_s)
                hps_pkg::HA_CTRL:
                begin
                    flag_a_d = din_s[hps_pkg::HC_FLAG_A];
                    flag_b_d = din_s[hps_pkg::HC_FLAG_B];
                    mode_d = din_s[hps_pkg::HC_MODE];
                    req_en_d = din_s[hps_pkg::HC_REQ_EN];
                end
                hps_pkg::HA_CMD:
                begin
                    cmd_pend_d = din_s[hps_pkg::HCMD_PEND];
                    vector_d = din_s[hps_pkg::VEC_W-1:0];
                end
                hps_pkg::HA_HIGH:
                    tx_high_d = din_s;
                hps_pkg::HA_LOW:
                begin
                    core_word_d = {tx_high_q, din_s};
                    xfer_full_d = 1'b1;
                end
            endcase
        end
        // Core transmit word fills the receive bytes; set wins
        if (wr_tx)
        begin
            rx_high_d = hwdata[hps_pkg::WORD_W-1:hps_pkg::BYTE_W];
            rx_low_d = hwdata[hps_pkg::BYTE_W-1:0];
            rx_full_d = 1'b1;
        end
        // Both to-host flags change in one edge
        if (wr_ctrl)
            to_host_d = {hwdata[hps_pkg::CTRL_FLAG_B], hwdata[hps_pkg::CTRL_FLAG_A]};
        // Vector captured as the core sees the command arrive
        if (ev[hps_pkg::EV_CMD])
            vec_core_d = vector_q;
        // Read byte frozen for the whole host access
        if (acc_start && rw_s)
        begin
            unique case (ha_s)
                hps_pkg::HA_CTRL:
                    hdout_d = stat_now;
                hps_pkg::HA_CMD:
                    hdout_d = {cmd_pend_q, 2'h0, vector_q};
                hps_pkg::HA_HIGH:
                    hdout_d = rx_high_q;
                hps_pkg::HA_LOW:
                    hdout_d = rx_low_q;
            endcase
        end
        hoe_d = acc_start ? rw_s : (acc_end ? 1'b0 : hoe_q);
    end

    // Bus next state, zero wait states
    always_comb
    begin
        dp_wr_d = ahb_take && hwrite;
        dp_addr_d = ahb_take ? haddr[7:0] : dp_addr_q;
        hrdata_d = hrdata_q;
        host_request_flag_n_d = !stat_now[hps_pkg::HS_REQ];
        if (ahb_take && !hwrite)
        begin
            hrdata_d = '0;
            unique case (haddr[hps_pkg::ADDR_MSB:hps_pkg::ADDR_LSB])
                hps_pkg::ADDR_CTRL[hps_pkg::ADDR_MSB:hps_pkg::ADDR_LSB]:
                    hrdata_d[1:0] = to_host_q;
                hps_pkg::ADDR_STATUS[hps_pkg::ADDR_MSB:hps_pkg::ADDR_LSB]:
                begin
                    hrdata_d[hps_pkg::ST_RX_FULL] = core_rxf_s;
                    hrdata_d[hps_pkg::ST_TX_EMPTY] = core_txe_s;
                    hrdata_d[hps_pkg::ST_CMD] = cmd_core_s;
                    hrdata_d[hps_pkg::ST_FLAG_A] = fh_a_s;
                    hrdata_d[hps_pkg::ST_FLAG_B] = fh_b_s;
                    hrdata_d[hps_pkg::ST_MODE] = mode_s;
                end
                hps_pkg::ADDR_RXWORD[hps_pkg::ADDR_MSB:hps_pkg::ADDR_LSB]:
                    hrdata_d[hps_pkg::WORD_W-1:0] = core_word_q;
                hps_pkg::ADDR_VECTOR[hps_pkg::ADDR_MSB:hps_pkg::ADDR_LSB]:
                    hrdata_d[hps_pkg::VEC_W-1:0] = vec_core_q;
                hps_pkg::ADDR_IRQSTAT[hps_pkg::ADDR_MSB:hps_pkg::ADDR_LSB]:
                    hrdata_d[hps_pkg::IRQ_W-1:0] = irq_stat;
                hps_pkg::ADDR_IRQMASK[hps_pkg::ADDR_MSB:hps_pkg::ADDR_LSB]:
                    hrdata_d[hps_pkg::IRQ_W-1:0] = irq_mask;
                default:
                    hrdata_d = '0;
            endcase
        end
    end

    // Register all state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            en_prev_q <= 1'b1;
            acc_rd_q <= 1'b0;
            acc_addr_q <= '0;
            rx_high_q <= '0;
            rx_low_q <= '0;
            rx_full_q <= 1'b0;
            tx_high_q <= '0;
            xfer_full_q <= 1'b0;
            core_word_q <= '0;
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
            mode_q <= 1'b0;
            req_en_q <= 1'b0;
            cmd_pend_q <= 1'b0;
            vector_q <= '0;
            vec_core_q <= '0;
            to_host_q <= '0;
            hdout_q <= '0;
            hoe_q <= 1'b0;
            host_request_flag_n_q <= 1'b1;
            hrdata_q <= '0;
            dp_wr_q <= 1'b0;
            dp_addr_q <= '0;
            cmd_prev_q <= 1'b0;
            rxf_prev_q <= 1'b0;
            txe_prev_q <= 1'b0;
        end
        else
        begin
            en_prev_q <= en_prev_d;
            acc_rd_q <= acc_rd_d;
            acc_addr_q <= acc_addr_d;
            rx_high_q <= rx_high_d;
            rx_low_q <= rx_low_d;
            rx_full_q <= rx_full_d;
            tx_high_q <= tx_high_d;
            xfer_full_q <= xfer_full_d;
            core_word_q <= core_word_d;
            flag_a_q <= flag_a_d;
            flag_b_q <= flag_b_d;
            mode_q <= mode_d;
            req_en_q <= req_en_d;
            cmd_pend_q <= cmd_pend_d;
            vector_q <= vector_d;
            vec_core_q <= vec_core_d;
            to_host_q <= to_host_d;
            hdout_q <= hdout_d;
            hoe_q <= hoe_d;
            host_request_flag_n_q <= host_request_flag_n_d;
            hrdata_q <= hrdata_d;
            dp_wr_q <= dp_wr_d;
            dp_addr_q <= dp_addr_d;
            cmd_prev_q <= cmd_prev_d;
            rxf_prev_q <= rxf_prev_d;
            txe_prev_q <= txe_prev_d;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hresetn | 1'b1;
    assign hresp = hps_pkg::HRESP_OKAY;
    assign host_data_out = hdout_q;
    assign host_data_oe = hoe_q;
    assign host_request_n = host_request_flag_n_q;

    ////////////////////////////////////////////////////////////////////////
    property p_read_stable;
        @(posedge hclk) disable iff (!hresetn)
        host_data_oe && $past(host_data_oe) |-> $stable(host_data_out);
    endproperty
    a_read_stable: assert property (p_read_stable)
        else $error("host read byte changed during access");

    property p_low_moves;
        @(posedge hclk) disable iff (!hresetn)
        host_wr && ha_s == hps_pkg::HA_LOW |=> core_word_q == {$past(tx_high_q), $past(din_s)}
            && xfer_full_q;
    endproperty
    a_low_moves: assert property (p_low_moves)
        else $error("transmit bytes not moved to core word");

    property p_sync_delay;
        @(posedge hclk) disable iff (!hresetn)
        $rose(xfer_full_q) |-> ##2 core_rxf_s;
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("core receive flag not synchronised in two cycles");

    property p_status_read;
        @(posedge hclk) disable iff (!hresetn)
        acc_start && rw_s && ha_s == hps_pkg::HA_CTRL
            |=> host_data_out[hps_pkg::HS_RX_FULL] == $past(rx_full_q) && host_data_oe;
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("host status byte wrong");

    property p_cmd_event;
        @(posedge hclk) disable iff (!hresetn)
        $rose(cmd_core_s) |=> irq_stat[hps_pkg::EV_CMD] && vec_core_q == $past(vector_q);
    endproperty
    a_cmd_event: assert property (p_cmd_event)
        else $error("command not flagged to core");

    property p_ack_clears;
        @(posedge hclk) disable iff (!hresetn)
        wr_ack && !(host_wr && ha_s == hps_pkg::HA_CMD) |=> !cmd_pend_q ##2 !cmd_core_s;
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("command pending not withdrawn");

    property p_flags_pair;
        @(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> to_host_q == {$past(hwdata[hps_pkg::CTRL_FLAG_B]),
            $past(hwdata[hps_pkg::CTRL_FLAG_A])};
    endproperty
    a_flags_pair: assert property (p_flags_pair)
        else $error("to-host flags not written together");

    property p_oe_end;
        @(posedge hclk) disable iff (!hresetn)
        acc_end |=> !host_data_oe;
    endproperty
    a_oe_end: assert property (p_oe_end)
        else $error("host data still driven after access");
endmodule : hps_host_port

// *** sim/hps_host_model.sv ***
// Host processor model for the byte-wide host port
module hps_host_model (
    input wire logic hclk,
    output logic host_interface_enable_n,
    output logic host_read_write,
    output logic [1:0] host_addr,
    output logic [7:0] host_data_in,
    input wire logic [7:0] host_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        host_interface_enable_n = 1'b1;
        host_read_write = 1'b1;
        host_addr = 2'h0;
        host_data_in = 8'h5A;
    end
    // One access, enable low six cycles
    task acc(input logic rw, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
        host_interface_enable_n <= 1'b0;
        host_read_write <= rw;
        host_addr <= a;
        host_data_in <= d;
        repeat (6) @(posedge hclk);
        q = host_data_out;
        host_interface_enable_n <= 1'b1;
        host_data_in <= ~d; // Released bus shows no stale byte
        repeat (4) @(posedge hclk);
    endtask : acc
    // Status read twice until both agree
    task status(output logic [7:0] s);
        logic [7:0] a;
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b1, hps_pkg::HA_CTRL, 8'h00, a);
            acc(1'b1, hps_pkg::HA_CTRL, 8'h00, s);
            if (a === s) break;
        end
    endtask : status
    // Write only when transmit empty
    task send(input logic [15:0] w);
        logic [7:0] s;
        for (int i = 0; i < 8; i++)
        begin
            status(s);
            if (s[hps_pkg::HS_TX_EMPTY] === 1'b1) break;
        end
        acc(1'b0, hps_pkg::HA_HIGH, w[15:8], s);
        acc(1'b0, hps_pkg::HA_LOW, w[7:0], s);
    endtask : send
    // Read bytes only after receive full
    task recv(output logic [15:0] w);
        logic [7:0] s;
        for (int i = 0; i < 8; i++)
        begin
            status(s);
            if (s[hps_pkg::HS_RX_FULL] === 1'b1) break;
        end
        acc(1'b1, hps_pkg::HA_HIGH, 8'h00, w[15:8]);
        acc(1'b1, hps_pkg::HA_LOW, 8'h00, w[7:0]);
    endtask : recv
    // New vector only while command clear
    task cmd(input logic [4:0] v);
        logic [7:0] s;
        for (int i = 0; i < 8; i++)
        begin
            status(s);
            if (s[hps_pkg::HS_CMD] === 1'b0) break;
        end
        acc(1'b0, hps_pkg::HA_CMD, {3'b100, v}, s);
    endtask : cmd
endmodule : hps_host_model

// *** sim/test_host_port_status_sync.sv ***
// Testbench for the host port status and synchronisation block
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_host_port_status_sync;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, d;
    logic hreadyout, hresp, irq, hen_n, hrw, host_data_oe, host_request_n;
    logic [1:0] hadr;
    logic [7:0] hdi, host_data_out, s;
    logic [15:0] w;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    always #12.5 hclk = ~hclk;
    hps_host_port hps_host_port_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .host_interface_enable_n(hen_n), .host_read_write(hrw), .host_addr(hadr),
        .host_data_in(hdi), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .host_request_n(host_request_n));
    hps_host_model hps_host_model_i (.hclk(hclk), .host_interface_enable_n(hen_n),
        .host_read_write(hrw), .host_addr(hadr), .host_data_in(hdi),
        .host_data_out(host_data_out));
    // Verdict and end of run
    task end_sim;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    // Hang guard
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_fail++;
            end_sim();
        end
    end
    // AHB single word transfer
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK({irq, host_request_n, host_data_oe, hreadyout}, 4'b0101)
        repeat (3) @(posedge hclk);
        // Host word reaches core, event stays masked
        hps_host_model_i.send(16'hC33C);
        repeat (4) @(posedge hclk);
        ahb(1'b0, hps_pkg::ADDR_STATUS, 32'h0, d);
        `CHK(d[hps_pkg::ST_RX_FULL], 1'b1)
        `CHK(irq, 1'b0)
        ahb(1'b0, hps_pkg::ADDR_RXWORD, 32'h0, d);
        `CHK(d[15:0], 16'hC33C)
        ahb(1'b0, hps_pkg::ADDR_IRQSTAT, 32'h0, d);
        `CHK(d[hps_pkg::EV_RX], 1'b1)
        ahb(1'b1, hps_pkg::ADDR_IRQMASK, 32'h1, d);
        repeat (2) @(posedge hclk);
        `CHK(irq, 1'b1)
        ahb(1'b1, hps_pkg::ADDR_IRQSTAT, 32'h7, d);
        repeat (2) @(posedge hclk);
        `CHK(irq, 1'b0)
        // Core word to host, receive full then clears
        ahb(1'b1, hps_pkg::ADDR_TXWORD, 32'h0000A55A, d);
        hps_host_model_i.recv(w);
        `CHK(w, 16'hA55A)
        hps_host_model_i.status(s);
        `CHK({s[hps_pkg::HS_RX_FULL], s[hps_pkg::HS_TX_EMPTY]}, 2'b01)
        `CHK(s[hps_pkg::HS_TRANSMITTER_READY_FLAG], 1'b1)
        // Every to-host flag code
        for (int k = 0; k < 4; k++)
        begin
            ahb(1'b1, hps_pkg::ADDR_CTRL, 32'(k), d);
            hps_host_model_i.status(s);
            `CHK({s[hps_pkg::HS_FLAG_B], s[hps_pkg::HS_FLAG_A]}, 2'(k))
        end
        // Every from-host flag and mode code
        for (int k = 0; k < 8; k++)
        begin
            hps_host_model_i.acc(1'b0, hps_pkg::HA_CTRL, 8'(k), s);
            repeat (4) @(posedge hclk);
            ahb(1'b0, hps_pkg::ADDR_STATUS, 32'h0, d);
            `CHK(d[5:3], 3'(k))
        end
        // Command with vector, then acknowledged
        hps_host_model_i.cmd(5'h15);
        repeat (4) @(posedge hclk);
        ahb(1'b0, hps_pkg::ADDR_VECTOR, 32'h0, d);
        `CHK(d[4:0], 5'h15)
        ahb(1'b0, hps_pkg::ADDR_IRQSTAT, 32'h0, d);
        `CHK(d[hps_pkg::EV_CMD], 1'b1)
        ahb(1'b1, hps_pkg::ADDR_CMDACK, 32'h1, d);
        hps_host_model_i.status(s);
        `CHK(s[hps_pkg::HS_CMD], 1'b0)
        // Host withdraws a command; the core may still have taken it
        hps_host_model_i.cmd(5'h0A);
        hps_host_model_i.acc(1'b0, hps_pkg::HA_CMD, 8'h0A, s);
        hps_host_model_i.status(s);
        `CHK(s[hps_pkg::HS_CMD], 1'b0)
        ahb(1'b0, hps_pkg::ADDR_VECTOR, 32'h0, d);
        `CHK(d[4:0], 5'h0A)
        // Request on transmit empty, unmapped read
        hps_host_model_i.acc(1'b0, hps_pkg::HA_CTRL, 8'h08, s);
        repeat (4) @(posedge hclk);
        `CHK(host_request_n, 1'b0)
        ahb(1'b0, 8'h20, 32'h0, d);
        `CHK({hresp, d}, {hps_pkg::HRESP_OKAY, 32'h0})
        end_sim();
    end
endmodule : test_host_port_status_sync
